// ===== core/una_defines.svh
// Offsets, field positions, reset values and codes of the network UART.
// Included by the baud generator, receiver and core design files; definitions only.
`ifndef UNA_DEFINES_SVH
`define UNA_DEFINES_SVH

// Register byte offsets
`define UNA_OFF_DATA 8'h00
`define UNA_OFF_INTDIV 8'h04
`define UNA_OFF_FRACDIV 8'h08
`define UNA_OFF_SCRATCH 8'h0C
`define UNA_OFF_NETEN 8'h10
`define UNA_OFF_NETID 8'h14
`define UNA_OFF_NODEADR 8'h18
`define UNA_OFF_BASEID 8'h1C
`define UNA_OFF_LSR 8'h20
`define UNA_OFF_MSR 8'h24
`define UNA_OFF_IEN 8'h28
`define UNA_OFF_IRQST 8'h2C
`define UNA_OFF_IRQMSK 8'h30

// Fractional divider fields
`define UNA_FB_EN 15
`define UNA_FB_M_HI 12
`define UNA_FB_M_LO 11
`define UNA_FB_N_HI 10
`define UNA_FRAC_ONE 15'h0800

// Network enable fields
`define UNA_NE_MODE 7
`define UNA_NE_TX9 6
`define UNA_NE_RX9 5
`define UNA_NE_IRQ 4
`define UNA_NE_WORD9 3
`define UNA_NE_DRV 2
`define UNA_NE_POL 1
`define UNA_NE_ADDR 0

// Identification codes, bits 3-1
`define UNA_ID_MATCH 3'h6
`define UNA_ID_ADDRTX 3'h5
`define UNA_ID_LINE 3'h3
`define UNA_ID_RXFULL 3'h2
`define UNA_ID_TXEMPTY 3'h1
`define UNA_ID_MODEM 3'h0

// Sticky status bit positions
`define UNA_EV_MATCH 0
`define UNA_EV_ADDRTX 1
`define UNA_EV_RX 2
`define UNA_EV_TXE 3
`define UNA_EV_LINE 4
`define UNA_EV_MODEM 5

// Reset values
`define UNA_RST_INTDIV 16'h0001
`define UNA_RST_ZERO8 8'h00
`define UNA_RST_ZERO16 16'h0000

// Oversampling
`define UNA_OVS_LAST 4'hF
`define UNA_OVS_MID 4'h7
`endif

// ===== core/una_pkg.sv
// Types shared by the network UART design files.
// Needs no other file.
package una_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} una_rx_st_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} una_tx_st_t;
endpackage

// ===== core/una_baud_gen.sv
// Sixteen-times oversampling tick for the network UART.
// Assumes the divider fields stay stable while a frame is in flight.
`timescale 1ns/100ps
`include "una_defines.svh"
module una_baud_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divider settings
  input wire logic [15:0] int_div,
  input wire logic frac_baud_enable,
  input wire logic [1:0] frac_m_factor,
  input wire logic [10:0] frac_n_factor,
  // Oversample tick
  output logic tick
);
  logic [15:0] pcnt_r;
  logic pre_r;
  logic [14:0] acc_r;
  logic [2:0] m_eff;
  logic [14:0] thr;
  logic [14:0] sum;

  // Field value zero stands for M of four
  assign m_eff = (frac_m_factor == 2'h0) ? 3'h4 : {1'b0, frac_m_factor};
  assign thr = {1'b0, m_eff, frac_n_factor};
  assign sum = acc_r + `UNA_FRAC_ONE;

  always_ff @(posedge clk) begin
    if (rst || pcnt_r + 16'h0001 >= int_div) begin
      pcnt_r <= `UNA_RST_ZERO16;
    end else begin
      pcnt_r <= pcnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_r <= 1'b0;
    end else begin
      pre_r <= (pcnt_r + 16'h0001 >= int_div);
    end
  end

  // Fractional mode stretches the integer rate by M + N/2048
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= 15'h0000;
      tick <= 1'b0;
    end else if (!frac_baud_enable) begin
      acc_r <= 15'h0000;
      tick <= pre_r;
    end else if (pre_r) begin
      if (sum >= thr) begin
        acc_r <= sum - thr;
        tick <= 1'b1;
      end else begin
        acc_r <= sum;
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

  a_int_tick: assert property (@(posedge clk) disable iff (rst)
    !frac_baud_enable && pre_r |=> tick)
    else $error("integer divider tick missing");
  // An M of one may legally tick on back-to-back cycles
  a_frac_slow: assert property (@(posedge clk) disable iff (rst)
    frac_baud_enable && frac_m_factor != 2'h1 && tick |=> !tick)
    else $error("fractional tick on back-to-back cycles");
endmodule

// ===== core/una_rx.sv
// Receiver for 8 or 9 bit characters, sampled at mid-bit.
// Assumes rx_in is already synchronous to clk.
`timescale 1ns/100ps
`include "una_defines.svh"
module una_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Line
  input wire logic rx_in,
  input wire logic tick,
  input wire logic nine_bits,
  // Character out
  output logic done,
  output logic [8:0] data,
  output logic frame_err
);
  una_pkg::una_rx_st_t st_r;
  logic [3:0] cnt_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic [3:0] last_bit;

  assign last_bit = nine_bits ? 4'h8 : 4'h7;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= una_pkg::RX_IDLE;
      cnt_r <= 4'h0;
      bit_r <= 4'h0;
      sh_r <= 9'h000;
    end else if (st_r == una_pkg::RX_IDLE) begin
      cnt_r <= 4'h0;
      if (!rx_in) begin
        st_r <= una_pkg::RX_START;
      end
    end else if (tick) begin
      cnt_r <= cnt_r + 4'h1;
      unique case (st_r)
        una_pkg::RX_START: begin
          if (cnt_r == `UNA_OVS_MID) begin
            cnt_r <= 4'h0;
            bit_r <= 4'h0;
            st_r <= rx_in ? una_pkg::RX_IDLE : una_pkg::RX_DATA;
          end
        end
        una_pkg::RX_DATA: begin
          if (cnt_r == `UNA_OVS_LAST) begin
            sh_r <= {rx_in, sh_r[8:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == last_bit) begin
              st_r <= una_pkg::RX_STOP;
            end
          end
        end
        una_pkg::RX_STOP: begin
          if (cnt_r == `UNA_OVS_LAST) begin
            st_r <= una_pkg::RX_IDLE;
          end
        end
        una_pkg::RX_IDLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      data <= 9'h000;
      frame_err <= 1'b0;
    end else begin
      done <= (st_r == una_pkg::RX_STOP) && tick && (cnt_r == `UNA_OVS_LAST);
      if ((st_r == una_pkg::RX_STOP) && tick && (cnt_r == `UNA_OVS_LAST)) begin
        data <= nine_bits ? sh_r : {1'b0, sh_r[8:1]};
        frame_err <= !rx_in;
      end
    end
  end

  a_rx_pulse: assert property (@(posedge clk) disable iff (rst)
    done |=> !done)
    else $error("receive done longer than one cycle");
endmodule

// ===== core/una_core.sv
// Network addressable UART: registers, transmitter, address match, irqs.
// Assumes a single clock, synchronous pins and a one-cycle register port.
`timescale 1ns/100ps
`include "una_defines.svh"
module una_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Serial line
  input wire logic rx_in,
  output logic serial_tx_pin,
  output logic serial_tx_pin_oe,
  // Modem lines
  input wire logic [3:0] modem_in,
  // Interrupt
  output logic irq
);
  logic [15:0] int_div_r;
  logic [15:0] fractional_baud_divider_r;
  logic [7:0] scratch_address_flag_r;
  logic [7:0] network_enable_r;
  logic [7:0] node_address_r;
  logic [3:0] ien_r;
  logic [5:0] irq_st_r;
  logic [5:0] irq_msk_r;
  logic [8:0] rx_holding_reg_r;
  logic [8:0] tx_holding_reg_r;
  logic data_ready_r, overrun_r, frame_r, tx_full_r, tx_empty_pend_r;
  logic match_pend_r, addrtx_pend_r;
  logic [3:0] modem_prev_r, modem_delta_r;
  una_pkg::una_tx_st_t tx_st_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_cnt_r, tx_bits_r;
  logic tx_was_addr_r;
  logic tick, rx_done, rx_ferr;
  logic [8:0] rx_data;
  logic net_on, tx9, rx9, word9, rx_is_addr, match, tx_load, tx_end;
  logic ld_marker, line_pend, modem_pend, rx_pend, txe_pend;
  logic [3:0] net_ident, base_ident;
  logic [5:0] ev;
  logic [7:0] line_status_reg, modem_status_reg;
  logic w_data, r_data, r_lsr, r_msr, r_base;

  // Network bits act only while network mode is on
  assign net_on = network_enable_r[`UNA_NE_MODE];
  assign tx9 = net_on && network_enable_r[`UNA_NE_TX9];
  assign rx9 = net_on && network_enable_r[`UNA_NE_RX9];
  assign word9 = net_on && network_enable_r[`UNA_NE_WORD9];

  assign w_data = wr && (addr == `UNA_OFF_DATA);
  assign r_data = rd && (addr == `UNA_OFF_DATA);
  assign r_lsr = rd && (addr == `UNA_OFF_LSR);
  assign r_msr = rd && (addr == `UNA_OFF_MSR);
  assign r_base = rd && (addr == `UNA_OFF_BASEID);

  una_baud_gen u_baud (
    .clk(clk),
    .rst(rst),
    .int_div(int_div_r),
    .frac_baud_enable(fractional_baud_divider_r[`UNA_FB_EN]),
    .frac_m_factor(fractional_baud_divider_r[`UNA_FB_M_HI:`UNA_FB_M_LO]),
    .frac_n_factor(fractional_baud_divider_r[`UNA_FB_N_HI:0]),
    .tick(tick)
  );

  una_rx u_rx (
    .clk(clk),
    .rst(rst),
    .rx_in(rx_in),
    .tick(tick),
    .nine_bits(rx9 || word9),
    .done(rx_done),
    .data(rx_data),
    .frame_err(rx_ferr)
  );

  // Marker polarity bit flips which marker level means address
  assign rx_is_addr = rx9 && !word9 &&
    (rx_data[8] ^ network_enable_r[`UNA_NE_POL]);
  // Eight-bit node address covers all 256 nodes
  assign match = rx_done && rx_is_addr &&
    (rx_data[7:0] == node_address_r);

  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      int_div_r <= `UNA_RST_INTDIV;
      fractional_baud_divider_r <= `UNA_RST_ZERO16;
      scratch_address_flag_r <= `UNA_RST_ZERO8;
      node_address_r <= `UNA_RST_ZERO8;
      ien_r <= 4'h0;
      irq_msk_r <= 6'h00;
    end else if (wr) begin
      unique case (addr)
        `UNA_OFF_INTDIV: int_div_r <= wdata;
        `UNA_OFF_FRACDIV: fractional_baud_divider_r <= wdata & 16'h9FFF;
        `UNA_OFF_SCRATCH: scratch_address_flag_r <= wdata[7:0];
        `UNA_OFF_NODEADR: node_address_r <= wdata[7:0];
        `UNA_OFF_IEN: ien_r <= wdata[3:0];
        `UNA_OFF_IRQMSK: irq_msk_r <= wdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // Address flag drops once the address character has gone out
  always_ff @(posedge clk) begin
    if (rst) begin
      network_enable_r <= `UNA_RST_ZERO8;
    end else if (wr && addr == `UNA_OFF_NETEN) begin
      network_enable_r <= wdata[7:0];
    end else if (tx_end && tx_was_addr_r) begin
      network_enable_r[`UNA_NE_ADDR] <= 1'b0;
    end
  end

  // Transmitter
  assign tx_load = (tx_st_r == una_pkg::TX_IDLE) && tx_full_r;
  assign tx_end = (tx_st_r == una_pkg::TX_SHIFT) && tick &&
    (tx_cnt_r == `UNA_OVS_LAST) && (tx_bits_r == 4'h1);
  assign ld_marker = network_enable_r[`UNA_NE_ADDR] ||
    scratch_address_flag_r[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_r <= una_pkg::TX_IDLE;
      tx_sh_r <= 11'h7FF;
      tx_cnt_r <= 4'h0;
      tx_bits_r <= 4'h0;
      tx_was_addr_r <= 1'b0;
    end else if (tx_load) begin
      tx_st_r <= una_pkg::TX_SHIFT;
      tx_cnt_r <= 4'h0;
      // Nine-bit data wins over the marker when both are set
      if (word9) begin
        tx_sh_r <= {1'b1, tx_holding_reg_r, 1'b0};
        tx_bits_r <= 4'hB;
        tx_was_addr_r <= 1'b0;
      end else if (tx9) begin
        tx_sh_r <= {1'b1, ld_marker, tx_holding_reg_r[7:0], 1'b0};
        tx_bits_r <= 4'hB;
        tx_was_addr_r <= ld_marker;
      end else begin
        tx_sh_r <= {2'h3, tx_holding_reg_r[7:0], 1'b0};
        tx_bits_r <= 4'hA;
        tx_was_addr_r <= 1'b0;
      end
    end else if ((tx_st_r == una_pkg::TX_SHIFT) && tick) begin
      tx_cnt_r <= tx_cnt_r + 4'h1;
      if (tx_cnt_r == `UNA_OVS_LAST) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_bits_r <= tx_bits_r - 4'h1;
        if (tx_bits_r == 4'h1) begin
          tx_st_r <= una_pkg::TX_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_holding_reg_r <= 9'h000;
      tx_full_r <= 1'b0;
    end else if (w_data) begin
      tx_holding_reg_r <= wdata[8:0];
      tx_full_r <= 1'b1;
    end else if (tx_load) begin
      tx_full_r <= 1'b0;
    end
  end

  // Pin drive is gated only in network mode
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_tx_pin <= 1'b1;
      serial_tx_pin_oe <= 1'b1;
    end else begin
      serial_tx_pin <= (tx_st_r == una_pkg::TX_SHIFT) ? tx_sh_r[0] : 1'b1;
      serial_tx_pin_oe <= !net_on || network_enable_r[`UNA_NE_DRV];
    end
  end

  // Receive holding and line status; a new event beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_holding_reg_r <= 9'h000;
      data_ready_r <= 1'b0;
      overrun_r <= 1'b0;
      frame_r <= 1'b0;
    end else begin
      if (rx_done && (!rx9 || !rx_is_addr || match)) begin
        rx_holding_reg_r <= rx_data;
        data_ready_r <= 1'b1;
        overrun_r <= (overrun_r && !r_lsr) || (data_ready_r && !r_data);
      end else if (r_data) begin
        data_ready_r <= 1'b0;
      end else if (r_lsr) begin
        overrun_r <= 1'b0;
      end
      if (rx_done && rx_ferr) begin
        frame_r <= 1'b1;
      end else if (r_lsr) begin
        frame_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      match_pend_r <= 1'b0;
    end else if (match) begin
      match_pend_r <= 1'b1;
    end else if (r_data || !net_on) begin
      match_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addrtx_pend_r <= 1'b0;
      tx_empty_pend_r <= 1'b0;
    end else begin
      if (tx_end && tx_was_addr_r && !tx_full_r && !w_data) begin
        addrtx_pend_r <= 1'b1;
      end else if (w_data || r_base) begin
        addrtx_pend_r <= 1'b0;
      end
      if (tx_load) begin
        tx_empty_pend_r <= 1'b1;
      end else if (w_data || r_base) begin
        tx_empty_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      modem_prev_r <= 4'h0;
      modem_delta_r <= 4'h0;
    end else begin
      modem_prev_r <= modem_in;
      modem_delta_r <= (modem_delta_r & {4{!r_msr}}) |
        (modem_in ^ modem_prev_r);
    end
  end

  // Pending conditions and identification
  assign line_pend = ien_r[2] && (overrun_r || frame_r);
  assign rx_pend = ien_r[0] && data_ready_r;
  assign txe_pend = ien_r[1] && tx_empty_pend_r;
  assign modem_pend = ien_r[3] && (modem_delta_r != 4'h0);

  function automatic logic [3:0] ident(input logic mt, input logic at,
                                        input logic full);
    logic [3:0] r;
    r = 4'h1;
    if (line_pend) begin
      r = {`UNA_ID_LINE, 1'b0};
    end else if (mt) begin
      r = full ? {`UNA_ID_MATCH, 1'b0} : {`UNA_ID_RXFULL, 1'b0};
    end else if (rx_pend) begin
      r = {`UNA_ID_RXFULL, 1'b0};
    end else if (at) begin
      r = full ? {`UNA_ID_ADDRTX, 1'b0} : {`UNA_ID_TXEMPTY, 1'b0};
    end else if (txe_pend) begin
      r = {`UNA_ID_TXEMPTY, 1'b0};
    end else if (modem_pend) begin
      r = {`UNA_ID_MODEM, 1'b0};
    end
    return r;
  endfunction

  assign net_ident = ident(match_pend_r && network_enable_r[`UNA_NE_IRQ],
    addrtx_pend_r && network_enable_r[`UNA_NE_IRQ], 1'b1);
  assign base_ident = ident(match_pend_r && network_enable_r[`UNA_NE_IRQ],
    addrtx_pend_r && network_enable_r[`UNA_NE_IRQ], 1'b0);

  assign line_status_reg = {1'b0, !tx_full_r && tx_st_r == una_pkg::TX_IDLE,
    !tx_full_r, 1'b0, frame_r, 1'b0, overrun_r, data_ready_r};
  assign modem_status_reg = {modem_in, modem_delta_r};

  // Sticky irq status, write one to clear, events win
  assign ev = {modem_in != modem_prev_r, rx_done && rx_ferr, tx_load, rx_done,
    tx_end && tx_was_addr_r && network_enable_r[`UNA_NE_IRQ],
    match && network_enable_r[`UNA_NE_IRQ]};

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_st_r <= 6'h00;
    end else if (wr && addr == `UNA_OFF_IRQST) begin
      irq_st_r <= (irq_st_r & ~wdata[5:0]) | ev;
    end else begin
      irq_st_r <= irq_st_r | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (irq_st_r & irq_msk_r) != 6'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `UNA_RST_ZERO16;
    end else if (rd) begin
      unique case (addr)
        `UNA_OFF_DATA: rdata <= {7'h00, rx_holding_reg_r};
        `UNA_OFF_INTDIV: rdata <= int_div_r;
        `UNA_OFF_FRACDIV: rdata <= fractional_baud_divider_r;
        `UNA_OFF_SCRATCH: rdata <= {8'h00, scratch_address_flag_r};
        `UNA_OFF_NETEN: rdata <= {8'h00, network_enable_r};
        `UNA_OFF_NETID: rdata <= {12'h000, net_ident};
        `UNA_OFF_NODEADR: rdata <= {8'h00, node_address_r};
        `UNA_OFF_BASEID: rdata <= {13'h0000, base_ident[2:0]};
        `UNA_OFF_LSR: rdata <= {8'h00, line_status_reg};
        `UNA_OFF_MSR: rdata <= {8'h00, modem_status_reg};
        `UNA_OFF_IEN: rdata <= {12'h000, ien_r};
        `UNA_OFF_IRQST: rdata <= {10'h000, irq_st_r};
        `UNA_OFF_IRQMSK: rdata <= {10'h000, irq_msk_r};
        default: rdata <= `UNA_RST_ZERO16;
      endcase
    end else begin
      rdata <= `UNA_RST_ZERO16;
    end
  end

  a_pin_hiz: assert property (@(posedge clk) disable iff (rst)
    net_on && !network_enable_r[`UNA_NE_DRV] |=> !serial_tx_pin_oe)
    else $error("transmit pin driven while driver off");
  a_normal_drive: assert property (@(posedge clk) disable iff (rst)
    !net_on |=> serial_tx_pin_oe)
    else $error("transmit pin not driven in normal mode");
  a_match_set: assert property (@(posedge clk) disable iff (rst)
    match |=> match_pend_r ##1
    (match_pend_r || $past(r_data) || !$past(net_on)))
    else $error("address match not recorded");
  a_match_code: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `UNA_OFF_NETID && match_pend_r &&
    network_enable_r[`UNA_NE_IRQ] && !line_pend
    |=> rdata[3:0] == 4'hC)
    else $error("match code not reported");
  a_match_clear: assert property (@(posedge clk) disable iff (rst)
    r_data && !match |=> !match_pend_r)
    else $error("match not cleared by data read");
  a_addrtx_clear: assert property (@(posedge clk) disable iff (rst)
    w_data |=> !addrtx_pend_r)
    else $error("address sent condition survived write");
  a_line_clear: assert property (@(posedge clk) disable iff (rst)
    r_lsr && !rx_done |=> !overrun_r && !frame_r)
    else $error("line status not cleared by read");
  a_marker_load: assert property (@(posedge clk) disable iff (rst)
    tx_load && tx9 && !word9 |=> tx_sh_r[9] == $past(ld_marker))
    else $error("marker bit wrong in frame");
  a_none_code: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `UNA_OFF_NETID && !line_pend && !rx_pend && !txe_pend &&
    !modem_pend && !match_pend_r && !addrtx_pend_r
    |=> rdata[3:0] == 4'h1)
    else $error("idle identification wrong");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    (irq_st_r & irq_msk_r) != 6'h00 |=> irq)
    else $error("irq output low with unmasked status");

  c_match: cover property (@(posedge clk) disable iff (rst) match);
  c_addr_sent: cover property (@(posedge clk) disable iff (rst)
    tx_end && tx_was_addr_r);
  c_rx_data: cover property (@(posedge clk) disable iff (rst)
    rx_done && !rx_is_addr);
endmodule

// ===== bench/una_node_model.sv
// Remote node on the shared serial line.
// Assumes 16 core clocks a bit (integer divider of 1).
`timescale 1ns/100ps
module una_node_model (
  // Clock
  input wire logic clk,
  // Lines
  output logic line_out,
  input wire logic line_in
);
  initial line_out = 1'b1;
  // Start, eight bits LSB first, marker in the parity slot, stop
  task automatic send(input logic [8:0] ch);
    logic [10:0] f;
    f = {1'b1, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (15) @(posedge clk);
    end
  endtask
  // Mid-bit sampling; a released line reads high through its pull-up
  task automatic recv(output logic [8:0] ch);
    @(negedge line_in);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge clk);
      ch[i] = line_in;
    end
  endtask
endmodule

// ===== bench/una_core_tb.sv
// Self-checking bench of the network UART core.
// Assumes a divider of 1 and a pulled-up transmit line.
`timescale 1ns/100ps
module una_core_tb;
  typedef struct packed {logic [7:0] a; logic [15:0] d, e;} una_row_t;
  typedef struct packed {logic [7:0] ne, sc; logic [8:0] d, e;} una_tx_t;
  typedef struct packed {logic [7:0] ne; logic [8:0] f;
    logic [15:0] id; logic q;} una_rx_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] modem_in = 4'h0;
  logic [15:0] rdata, got, cyc;
  logic rx_in, serial_tx_pin, serial_tx_pin_oe, irq;
  logic [8:0] ch;
  int fail_count = 0;
  int samples_checked = 0;
  wire line = serial_tx_pin_oe ? serial_tx_pin : 1'b1;
  una_row_t rows[8] = '{'{8'h04, 16'h0001, 16'h0001},
    '{8'h08, 16'h7FFF, 16'h1FFF}, '{8'h0C, 16'h00FE, 16'h00FE},
    '{8'h18, 16'h00A5, 16'h00A5}, '{8'h30, 16'h0001, 16'h0001},
    '{8'h3C, 16'hFFFF, 16'h0000}, '{8'h14, 16'hFFFF, 16'h0001},
    '{8'h28, 16'h0009, 16'h0009}};
  una_tx_t txr[5] = '{'{8'hD5, 8'hFE, 9'h033, 9'h133},
    '{8'hC4, 8'h01, 9'h05A, 9'h15A}, '{8'hC4, 8'h00, 9'h05A, 9'h05A},
    '{8'h8C, 8'h00, 9'h1C3, 9'h1C3}, '{8'h05, 8'h00, 9'h0A5, 9'h1A5}};
  una_rx_t rxr[4] = '{'{8'hB0, 9'h1A5, 16'h000C, 1'b1},
    '{8'hA0, 9'h111, 16'h0001, 1'b0}, '{8'hA0, 9'h042, 16'h0004, 1'b0},
    '{8'hB2, 9'h0A5, 16'h000C, 1'b1}};

  always #5 clk = ~clk;

  una_core DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_in(rx_in),
    .serial_tx_pin(serial_tx_pin), .serial_tx_pin_oe(serial_tx_pin_oe),
    .modem_in(modem_in), .irq(irq));
  una_node_model node (.clk(clk), .line_out(rx_in), .line_in(line));

  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run needs about 2300 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 check("pins", {13'h0, irq, serial_tx_pin, serial_tx_pin_oe}, 16'h3);
    rreg(8'h04, got);
    check("intdiv reset", got, 16'h0001);
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, got);
      check("register", got, rows[i].e);
    end
    foreach (txr[i]) begin
      wreg(8'h10, {8'h00, txr[i].ne});
      wreg(8'h0C, {8'h00, txr[i].sc});
      wreg(8'h00, {7'h00, txr[i].d});
      node.recv(ch);
      check("tx frame", {7'h00, ch}, {7'h00, txr[i].e});
      repeat (40) @(posedge clk);
      if (i == 0) begin
        rreg(8'h14, got);
        check("addr sent id", got, 16'h000A);
        rreg(8'h1C, got);
        rreg(8'h14, got);
        check("id cleared", got, 16'h0001);
      end
    end
    // M of two halves the tick rate: four high data bits span 128 cycles
    wreg(8'h08, 16'h9000);
    wreg(8'h00, 16'h000F);
    @(negedge line);
    @(posedge line);
    cyc = 16'h0000;
    while (line === 1'b1) begin
      @(posedge clk);
      #1 cyc++;
    end
    check("frac bit time", cyc, 16'h0080);
    repeat (250) @(posedge clk);
    wreg(8'h08, 16'h0000);
    wreg(8'h10, 16'h0080);
    @(posedge clk);
    #1 check("pin three-state", {15'h0, serial_tx_pin_oe}, 16'h0);
    foreach (rxr[i]) begin
      wreg(8'h10, {8'h00, rxr[i].ne});
      wreg(8'h2C, 16'h003F);
      rreg(8'h1C, got);
      rreg(8'h00, got);
      node.send(rxr[i].f);
      repeat (20) @(posedge clk);
      rreg(8'h14, got);
      check("rx id", got, rxr[i].id);
      check("irq", {15'h0, irq}, {15'h0, rxr[i].q});
      rreg(8'h00, got);
      rreg(8'h14, got);
      check("rx id cleared", got, 16'h0001);
    end
    modem_in <= 4'h1;
    repeat (3) @(posedge clk);
    rreg(8'h14, got);
    check("modem id", got, 16'h0000);
    rreg(8'h24, got);
    rreg(8'h14, got);
    check("modem cleared", got, 16'h0001);
    give_verdict();
  end
endmodule
